// file: hdl/isc_pkg.sv
package isc_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NSRC      = 32;
    localparam int SRC_W     = 5;
    localparam int PRI_W     = 3;
    localparam int ADDR_W    = 9;
    localparam int DATA_W    = 32;
    localparam int STK_DEPTH = 8;
    localparam int SP_W      = 4;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_SMR_BASE = 9'h000;
    localparam logic [ADDR_W-1:0] ADDR_SVR_BASE = 9'h080;
    localparam logic [ADDR_W-1:0] ADDR_IVR      = 9'h100;
    localparam logic [ADDR_W-1:0] ADDR_FVR      = 9'h104;
    localparam logic [ADDR_W-1:0] ADDR_ISR      = 9'h108;
    localparam logic [ADDR_W-1:0] ADDR_IPR      = 9'h10C;
    localparam logic [ADDR_W-1:0] ADDR_IMR      = 9'h110;
    localparam logic [ADDR_W-1:0] ADDR_CISR     = 9'h114;
    localparam logic [ADDR_W-1:0] ADDR_IECR     = 9'h120;
    localparam logic [ADDR_W-1:0] ADDR_IDCR     = 9'h124;
    localparam logic [ADDR_W-1:0] ADDR_ICCR     = 9'h128;
    localparam logic [ADDR_W-1:0] ADDR_ISCR     = 9'h12C;
    localparam logic [ADDR_W-1:0] ADDR_EOICR    = 9'h130;
    localparam logic [ADDR_W-1:0] ADDR_DCR      = 9'h138;
    localparam logic [ADDR_W-1:0] ADDR_FFR      = 9'h140;
    localparam logic [1:0]        ADDR_ALIGNED  = 2'h0;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int SMR_TYPE_LSB  = 5;
    localparam int TYPE_EDGE_BIT = 0;
    localparam int TYPE_POL_BIT  = 1;
    localparam int DCR_GMSK_BIT  = 0;
    localparam int CISR_IRQ_BIT  = 0;
    localparam int CISR_FIQ_BIT  = 1;

    localparam int SRC_FAST = 0;
    localparam int SRC_SYS  = 1;

    localparam logic [DATA_W-1:0] WORD_ZERO     = 32'h00000000;
    localparam logic [DATA_W-1:0] FAST_SRC_MASK = 32'h00000001;
    localparam logic [PRI_W-1:0]  PRI_RST       = 3'h0;
    localparam logic [SP_W-1:0]   SP_EMPTY      = 4'h0;
    localparam logic [SP_W-1:0]   SP_ONE        = 4'h1;
    localparam logic [SP_W-1:0]   SP_FULL       = 4'h8;

    // Trigger types: level types sense a level, edge types latch an edge.
    typedef enum logic [1:0] {
        ISC_LOW_LEVEL,
        ISC_FALL_EDGE,
        ISC_HIGH_LEVEL,
        ISC_RISE_EDGE
    } isc_trig_t;

endpackage

// file: hdl/isc_top.sv
module isc_top
    import isc_pkg::*;
#(
    parameter int                NUM_SYS     = 4,
    parameter logic [NSRC-1:0]   EXT_SOURCES = 32'hE0000000
) (
    input  wire logic                  REF_CLK,
    input  wire logic                  NRST,
    input  wire logic [ADDR_W-1:0]     REG_ADDR,
    input  wire logic [DATA_W-1:0]     REG_WDATA,
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    output      logic [DATA_W-1:0]     REG_RDATA,
    input  wire logic                  FAST_REQUEST_PIN,
    input  wire logic [NUM_SYS-1:0]    SYSTEM_IRQS,
    input  wire logic [NSRC-1:2]       PERIPHERAL_SOURCES,
    input  wire logic [NSRC-1:2]       EXTERNAL_REQUEST_PINS,
    output      logic                  NORMAL_REQUEST_OUT_N,
    output      logic                  FAST_REQUEST_OUT_N,
    output      logic                  WAKEUP_OUT
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [NSRC-1:0]   sync1_q;
    logic [NSRC-1:0]   sync2_q;
    logic [NSRC-1:0]   act_prev_q;
    logic [NSRC-1:0]   edge_q;
    logic [NSRC-1:0]   edge_d;
    logic [NSRC-1:0]   imr_q;
    logic [NSRC-1:0]   ff_q;
    logic              gmsk_q;
    logic [DATA_W-1:0] svr_q     [NSRC];
    logic [PRI_W-1:0]  pri_q     [NSRC];
    isc_trig_t         trig_q    [NSRC];
    logic [SRC_W-1:0]  stk_num_q [STK_DEPTH];
    logic [PRI_W-1:0]  stk_pri_q [STK_DEPTH];
    logic [SP_W-1:0]   sp_q;
    logic              normal_request_out_n_n_q;
    logic              fast_request_out_n_n_q;
    logic              wake_q;
    logic [DATA_W-1:0] rdata_q;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire logic             aligned  = (REG_ADDR[1:0] == ADDR_ALIGNED);
    wire logic [SRC_W-1:0] reg_idx  = REG_ADDR[SRC_W+1:2];
    wire logic             in_smr   = aligned && (REG_ADDR >= ADDR_SMR_BASE) && (REG_ADDR < ADDR_SVR_BASE);
    wire logic             in_svr   = aligned && (REG_ADDR >= ADDR_SVR_BASE) && (REG_ADDR < ADDR_IVR);
    wire logic             wr_smr   = REG_WR && in_smr;
    wire logic             wr_svr   = REG_WR && in_svr;
    wire logic             wr_iecr  = REG_WR && (REG_ADDR == ADDR_IECR);
    wire logic             wr_idcr  = REG_WR && (REG_ADDR == ADDR_IDCR);
    wire logic             wr_iccr  = REG_WR && (REG_ADDR == ADDR_ICCR);
    wire logic             wr_iscr  = REG_WR && (REG_ADDR == ADDR_ISCR);
    wire logic             wr_eoi   = REG_WR && (REG_ADDR == ADDR_EOICR);
    wire logic             wr_dcr   = REG_WR && (REG_ADDR == ADDR_DCR);
    wire logic             wr_ffr   = REG_WR && (REG_ADDR == ADDR_FFR);
    wire logic             rd_ivr   = REG_RD && (REG_ADDR == ADDR_IVR);
    wire logic             rd_fvr   = REG_RD && (REG_ADDR == ADDR_FVR);

    // ------------------------------------------------------------------
    // Source input stage
    // ------------------------------------------------------------------
    wire logic [NSRC-1:0] raw_async = {EXTERNAL_REQUEST_PINS, 1'b0, FAST_REQUEST_PIN};
    wire logic            sys_or    = |SYSTEM_IRQS;
    wire logic [NSRC-1:0] set_cmd   = wr_iscr ? REG_WDATA : WORD_ZERO;
    wire logic [NSRC-1:0] clr_cmd   = wr_iccr ? REG_WDATA : WORD_ZERO;

    logic [NSRC-1:0] lvl;
    logic [NSRC-1:0] act;
    logic [NSRC-1:0] edge_mode;
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] auto_clr;

    // Bit i of every vector below belongs to source i.
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_src
            if (gi == SRC_FAST) begin : g_fast
                assign lvl[gi] = sync2_q[gi];
            end else if (gi == SRC_SYS) begin : g_sys
                assign lvl[gi] = sys_or;
            end else begin : g_per
                assign lvl[gi] = EXT_SOURCES[gi] ? sync2_q[gi] : PERIPHERAL_SOURCES[gi];
            end
            if ((gi == SRC_FAST) || EXT_SOURCES[gi]) begin : g_ext
                assign act[gi] = trig_q[gi][TYPE_POL_BIT] ? lvl[gi] : ~lvl[gi];
            end else begin : g_int
                assign act[gi] = lvl[gi];
            end
            assign edge_mode[gi] = trig_q[gi][TYPE_EDGE_BIT];
            assign pend[gi]      = edge_mode[gi] ? edge_q[gi] : act[gi];
            // An arriving edge or set command wins over any clear in the same cycle.
            assign edge_d[gi] = edge_mode[gi] &
                                ((act[gi] & ~act_prev_q[gi]) | set_cmd[gi] |
                                 (edge_q[gi] & ~clr_cmd[gi] & ~auto_clr[gi]));
        end
    endgenerate

    // ------------------------------------------------------------------
    // Priority selection
    // ------------------------------------------------------------------
    wire logic [NSRC-1:0] cand     = pend & imr_q & ~ff_q & ~FAST_SRC_MASK;
    wire logic [NSRC-1:0] fast_src = pend & imr_q & (ff_q | FAST_SRC_MASK);

    logic             best_found;
    logic [SRC_W-1:0] best_num;
    logic [PRI_W-1:0] best_pri;

    // Scanning downward with >= lets the lowest number win a tie.
    always_comb begin
        best_found = 1'b0;
        best_num   = '0;
        best_pri   = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (cand[i] && (!best_found || (pri_q[i] >= best_pri))) begin
                best_found = 1'b1;
                best_num   = SRC_W'(i);
                best_pri   = pri_q[i];
            end
        end
    end

    wire logic [2:0]       sp_top   = 3'(sp_q - SP_ONE);
    wire logic             stk_any  = (sp_q != SP_EMPTY);
    wire logic [PRI_W-1:0] cur_pri  = stk_any ? stk_pri_q[sp_top] : PRI_RST;
    wire logic [SRC_W-1:0] cur_num  = stk_any ? stk_num_q[sp_top] : '0;
    wire logic             take_ivr = rd_ivr && best_found;
    wire logic             push_ok  = take_ivr && (sp_q != SP_FULL);
    wire logic             pop_ok   = wr_eoi && stk_any;

    // Only a strictly higher priority than the one in service raises the line.
    wire logic irq_raw = best_found && (!stk_any || (best_pri > cur_pri)) && !rd_ivr;
    wire logic fiq_raw = |fast_src;

    assign auto_clr = (take_ivr ? (FAST_SRC_MASK << best_num) & ~ff_q : WORD_ZERO)
                    | (rd_fvr ? FAST_SRC_MASK : WORD_ZERO);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    wire logic [DATA_W-1:0] smr_rd  = {25'h0000000, trig_q[reg_idx], 2'h0, pri_q[reg_idx]};
    wire logic [DATA_W-1:0] cisr_rd = {30'h00000000, ~fast_request_out_n_n_q, ~normal_request_out_n_n_q};
    wire logic [DATA_W-1:0] rd_val  =
          in_smr                  ? smr_rd
        : in_svr                  ? svr_q[reg_idx]
        : (REG_ADDR == ADDR_IVR)  ? (best_found ? svr_q[best_num] : WORD_ZERO)
        : (REG_ADDR == ADDR_FVR)  ? svr_q[SRC_FAST]
        : (REG_ADDR == ADDR_ISR)  ? DATA_W'(cur_num)
        : (REG_ADDR == ADDR_IPR)  ? pend
        : (REG_ADDR == ADDR_IMR)  ? imr_q
        : (REG_ADDR == ADDR_CISR) ? cisr_rd
        : (REG_ADDR == ADDR_DCR)  ? DATA_W'(gmsk_q)
        : (REG_ADDR == ADDR_FFR)  ? ff_q
        : WORD_ZERO;

    // ------------------------------------------------------------------
    // Synchronisers and edge memory
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            sync1_q <= WORD_ZERO;
            sync2_q <= WORD_ZERO;
        end else begin
            sync1_q <= raw_async;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            act_prev_q <= WORD_ZERO;
            edge_q     <= WORD_ZERO;
        end else begin
            act_prev_q <= act;
            edge_q     <= edge_d;
        end
    end

    // ------------------------------------------------------------------
    // Mask, fast forcing and general mask
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            imr_q  <= WORD_ZERO;
            ff_q   <= WORD_ZERO;
            gmsk_q <= 1'b0;
        end else begin
            if (wr_iecr) begin
                imr_q <= imr_q | REG_WDATA;
            end else if (wr_idcr) begin
                imr_q <= imr_q & ~REG_WDATA;
            end
            if (wr_ffr) begin
                ff_q <= REG_WDATA & ~FAST_SRC_MASK;
            end
            if (wr_dcr) begin
                gmsk_q <= REG_WDATA[DCR_GMSK_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Source mode and handler address registers
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < NSRC; i++) begin
                pri_q[i]  <= PRI_RST;
                trig_q[i] <= ISC_LOW_LEVEL;
                svr_q[i]  <= WORD_ZERO;
            end
        end else begin
            if (wr_smr) begin
                pri_q[reg_idx]  <= REG_WDATA[PRI_W-1:0];
                trig_q[reg_idx] <= isc_trig_t'(REG_WDATA[SMR_TYPE_LSB+1:SMR_TYPE_LSB]);
            end
            if (wr_svr) begin
                svr_q[reg_idx] <= REG_WDATA;
            end
        end
    end

    // ------------------------------------------------------------------
    // Nesting stack
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            sp_q <= SP_EMPTY;
            for (int i = 0; i < STK_DEPTH; i++) begin
                stk_num_q[i] <= '0;
                stk_pri_q[i] <= PRI_RST;
            end
        end else if (push_ok) begin
            stk_num_q[sp_q[2:0]] <= best_num;
            stk_pri_q[sp_q[2:0]] <= best_pri;
            sp_q                 <= sp_q + SP_ONE;
        end else if (pop_ok) begin
            sp_q <= sp_q - SP_ONE;
        end
    end

    // ------------------------------------------------------------------
    // Request outputs and read data
    // ------------------------------------------------------------------
    // The block has no clock gate input; it runs on every rising edge of REF_CLK.
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            normal_request_out_n_n_q <= 1'b1;
            fast_request_out_n_n_q <= 1'b1;
            wake_q   <= 1'b0;
            rdata_q  <= WORD_ZERO;
        end else begin
            normal_request_out_n_n_q <= ~(irq_raw && !gmsk_q);
            fast_request_out_n_n_q <= ~(fiq_raw && !gmsk_q);
            wake_q   <= irq_raw || fiq_raw;
            rdata_q  <= REG_RD ? rd_val : WORD_ZERO;
        end
    end

    assign NORMAL_REQUEST_OUT_N = normal_request_out_n_n_q;
    assign FAST_REQUEST_OUT_N   = fast_request_out_n_n_q;
    assign WAKEUP_OUT           = wake_q;
    assign REG_RDATA            = rdata_q;

endmodule

// file: tb/isc_core_model.sv
module isc_core_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic irq_n,
    input  wire logic fiq_n,
    input  wire logic wake,
    output logic      irq_seen,
    output logic      fiq_seen,
    output logic      woken
);
    timeunit 1ns;
    timeprecision 1ps;
    // The core samples its active-low request inputs and the wake line.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_seen <= 1'b0;
            fiq_seen <= 1'b0;
            woken    <= 1'b0;
        end else begin
            irq_seen <= !irq_n;
            fiq_seen <= !fiq_n;
            woken    <= wake;
        end
    end
endmodule

// file: tb/isc_top_chk.sv
module isc_top_chk
    import isc_pkg::*;
(
    input wire logic              REF_CLK,
    input wire logic              NRST,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic              REG_WR,
    input wire logic              REG_RD,
    input wire logic [DATA_W-1:0] REG_RDATA,
    input wire logic              NORMAL_REQUEST_OUT_N,
    input wire logic              FAST_REQUEST_OUT_N,
    input wire logic              WAKEUP_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Shadow of the enable mask and the general mask.
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mask_q;
    logic [DATA_W-1:0] mask_d;
    logic              gmsk_q;
    logic              gmsk_d;
    wire               en_wr  = REG_WR && REG_ADDR == ADDR_IECR;
    wire               dis_wr = REG_WR && REG_ADDR == ADDR_IDCR;
    wire               dcr_wr = REG_WR && REG_ADDR == ADDR_DCR;
    assign mask_d = en_wr ? (mask_q | REG_WDATA) : (dis_wr ? (mask_q & ~REG_WDATA) : mask_q);
    assign gmsk_d = dcr_wr ? REG_WDATA[DCR_GMSK_BIT] : gmsk_q;
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            mask_q <= WORD_ZERO;
            gmsk_q <= 1'b0;
        end else begin
            mask_q <= mask_d;
            gmsk_q <= gmsk_d;
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);
    reset_release_a: assert property ($rose(NRST) |-> NORMAL_REQUEST_OUT_N && FAST_REQUEST_OUT_N)
        else $error("request line active right after reset");
    read_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == WORD_ZERO)
        else $error("read data not zero outside read answer cycle");
    unaligned_zero_a: assert property (REG_RD && REG_ADDR[1:0] != ADDR_ALIGNED |=> REG_RDATA == WORD_ZERO)
        else $error("unaligned read returned data");
    core_status_a: assert property (REG_RD && REG_ADDR == ADDR_CISR |=>
        REG_RDATA == {30'h00000000, !$past(FAST_REQUEST_OUT_N), !$past(NORMAL_REQUEST_OUT_N)})
        else $error("core status differs from request lines");
    ivr_drop_a: assert property (REG_RD && REG_ADDR == ADDR_IVR |=> NORMAL_REQUEST_OUT_N)
        else $error("normal line still low after vector read");
    wake_follows_a: assert property (!NORMAL_REQUEST_OUT_N || !FAST_REQUEST_OUT_N |-> WAKEUP_OUT)
        else $error("request without wake-up");
    mask_quiet_a: assert property ($past(mask_q) == WORD_ZERO |-> NORMAL_REQUEST_OUT_N && FAST_REQUEST_OUT_N)
        else $error("request while every source disabled");
    gmask_quiet_a: assert property ($past(gmsk_q) |-> NORMAL_REQUEST_OUT_N && FAST_REQUEST_OUT_N)
        else $error("request while general mask set");
    cover property (REG_RD && REG_ADDR == ADDR_IVR && !NORMAL_REQUEST_OUT_N);
    cover property (!FAST_REQUEST_OUT_N);
    cover property (WAKEUP_OUT && gmsk_q);
endmodule

bind isc_top isc_top_chk i_isc_top_chk (.REF_CLK(REF_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .NORMAL_REQUEST_OUT_N(NORMAL_REQUEST_OUT_N), .FAST_REQUEST_OUT_N(FAST_REQUEST_OUT_N),
    .WAKEUP_OUT(WAKEUP_OUT));

// file: tb/isc_top_test.sv
module isc_top_test
    import isc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              ref_clk = 1'b0;
    logic              nrst = 1'b0;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    wire  [DATA_W-1:0] reg_rdata;
    logic              fast_pin;
    logic [3:0]        sys_irqs;
    logic [NSRC-1:2]   per_src;
    logic [NSRC-1:2]   ext_pins;
    wire               normal_request_out_n_n, fast_request_out_n_n, wake, irq_seen, fiq_seen, woken;
    int                fail_count = 0;
    int                total_checks = 0;
    logic [DATA_W-1:0] exp_q[$];
    logic              rd_pend = 1'b0;
    logic [DATA_W-1:0] rnd;

    isc_top #(.NUM_SYS(4), .EXT_SOURCES(32'hE0000000)) i_isc_top (.REF_CLK(ref_clk), .NRST(nrst),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .FAST_REQUEST_PIN(fast_pin), .SYSTEM_IRQS(sys_irqs), .PERIPHERAL_SOURCES(per_src),
        .EXTERNAL_REQUEST_PINS(ext_pins), .NORMAL_REQUEST_OUT_N(normal_request_out_n_n), .FAST_REQUEST_OUT_N(fast_request_out_n_n),
        .WAKEUP_OUT(wake));
    isc_core_model i_isc_core_model (.clk(ref_clk), .rst_n(nrst), .irq_n(normal_request_out_n_n), .fiq_n(fast_request_out_n_n),
        .wake(wake), .irq_seen(irq_seen), .fiq_seen(fiq_seen), .woken(woken));

    always #2.5 ref_clk = ~ref_clk;

    task automatic cmp(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic cmp_line(input string what, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", what, e, s);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wait_line(input bit fast);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (!(fast ? fiq_seen : irq_seen) && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        cmp_line("request line", 1'b1, fast ? fiq_seen : irq_seen);
        @(posedge ref_clk);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge ref_clk) rd_pend <= reg_rd;
    always @(negedge ref_clk) begin
        if (rd_pend) cmp("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
    initial begin
        #20000ns;
        fail_count++;
        complete_run;
    end

    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, sys_irqs, per_src} = '0;
        fast_pin = 1'b1;
        ext_pins = '1;
        rnd = $urandom(45);
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(ADDR_IMR, WORD_ZERO);
        rd(ADDR_IPR, WORD_ZERO);
        rd(ADDR_ISR, WORD_ZERO);
        rd(ADDR_CISR, WORD_ZERO);
        rd(9'h1FC, WORD_ZERO);
        rd(ADDR_IPR | 9'h001, WORD_ZERO);
        for (int i = 0; i < NSRC; i++) begin
            rnd = $urandom & 32'h00000007;
            wr(ADDR_SMR_BASE + 9'(4 * i), rnd);
            rd(ADDR_SMR_BASE + 9'(4 * i), rnd);
            rnd = $urandom;
            wr(ADDR_SVR_BASE + 9'(4 * i), rnd);
            rd(ADDR_SVR_BASE + 9'(4 * i), rnd);
        end
        rnd = $urandom;
        wr(ADDR_IECR, rnd);
        rd(ADDR_IMR, rnd);
        wr(ADDR_IDCR, rnd & 32'h0000FFFF);
        rd(ADDR_IMR, rnd & 32'hFFFF0000);
        wr(ADDR_IDCR, 32'hFFFFFFFF);
        rd(ADDR_IMR, WORD_ZERO);
        sys_irqs <= 4'h4;
        per_src[5] <= 1'b1;
        @(posedge ref_clk);
        rd(ADDR_IPR, 32'h00000022);
        wr(ADDR_ICCR, 32'h00000022);
        wr(ADDR_ISCR, 32'h00000010);
        rd(ADDR_IPR, 32'h00000022);
        sys_irqs <= 4'h0;
        per_src[5] <= 1'b0;
        @(posedge ref_clk);
        rd(ADDR_IPR, WORD_ZERO);
        wr(ADDR_SMR_BASE + 9'h01C, 32'h00000023);
        wr(ADDR_SMR_BASE + 9'h020, 32'h00000021);
        wr(ADDR_SVR_BASE + 9'h01C, 32'h0000ABC0);
        wr(ADDR_ISCR, 32'h00000180);
        rd(ADDR_IPR, 32'h00000180);
        wr(ADDR_IECR, 32'h00000180);
        wait_line(1'b0);
        rd(ADDR_IVR, 32'h0000ABC0);
        rd(ADDR_IPR, 32'h00000100);
        rd(ADDR_ISR, 32'h00000007);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp_line("normal line", 1'b0, irq_seen);
        @(posedge ref_clk);
        wr(ADDR_EOICR, WORD_ZERO);
        wait_line(1'b0);
        wr(ADDR_ICCR, 32'h00000100);
        rd(ADDR_IPR, WORD_ZERO);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_SMR_BASE + 9'h07C, 32'(m) << SMR_TYPE_LSB);
            ext_pins[31] <= ~m[1];
            repeat (4) @(posedge ref_clk);
            wr(ADDR_ICCR, 32'h80000000);
            rd(ADDR_IPR, WORD_ZERO);
            ext_pins[31] <= m[1];
            if (m[0]) begin
                repeat (4) @(posedge ref_clk);
                ext_pins[31] <= ~m[1];
            end
            repeat (4) @(posedge ref_clk);
            rd(ADDR_IPR, 32'h80000000);
        end
        wr(ADDR_ICCR, 32'h80000000);
        fast_pin <= 1'b0;
        wr(ADDR_SMR_BASE, 32'h00000060);
        wr(ADDR_SVR_BASE, 32'h000055AA);
        wr(ADDR_ICCR, FAST_SRC_MASK);
        wr(ADDR_IECR, FAST_SRC_MASK);
        fast_pin <= 1'b1;
        wait_line(1'b1);
        rd(ADDR_CISR, 32'h00000002);
        rd(ADDR_FVR, 32'h000055AA);
        rd(ADDR_IPR, WORD_ZERO);
        wr(ADDR_SMR_BASE + 9'h024, 32'h00000020);
        wr(ADDR_FFR, 32'h00000200);
        wr(ADDR_ISCR, 32'h00000200);
        wr(ADDR_IECR, 32'h00000200);
        wait_line(1'b1);
        rd(ADDR_IVR, WORD_ZERO);
        rd(ADDR_IPR, 32'h00000200);
        wr(ADDR_ICCR, 32'h00000200);
        wr(ADDR_DCR, 32'h00000001);
        wr(ADDR_ISCR, 32'h00000080);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp_line("wake", 1'b1, woken);
        cmp_line("normal line", 1'b0, irq_seen);
        @(posedge ref_clk);
        wr(ADDR_DCR, WORD_ZERO);
        wait_line(1'b0);
        rd(ADDR_IVR, 32'h0000ABC0);
        wr(ADDR_EOICR, WORD_ZERO);
        complete_run;
    end
endmodule
